// file: core/acc_comparator_ctrl.sv
// Control and event logic for one analog comparator, with APB registers.
// Assumes the comparator output arrives asynchronously and the analog
// muxes and power switch follow the select outputs directly.
//
// Local design decisions: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ns
module acc_comparator_ctrl
    import acc_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic compare_raw_i,
    output logic analog_power_o,
    output logic positive_input_select_o,
    output logic [1:0] negative_input_select_o,
    output logic compare_out_pin_o,
    output logic compare_out_pin_oe_o,
    output logic compare_event_o,
    output logic irq_o
);

    // Register state
    acc_ctrl_t ctrl_q;
    logic [31:0] status_q;
    logic [31:0] mask_q;
    logic [31:0] prdata_q;
    logic sync1_q;
    logic sync2_q;
    logic sample_q;
    logic event_q;
    logic pin_q;

    // Bus decode
    wire logic setup_phase = psel_i && !penable_i;
    wire logic access_phase = psel_i && penable_i;
    wire logic hit_ctrl = (paddr_i == ACC_OFF_CTRL);
    wire logic hit_status = (paddr_i == ACC_OFF_STATUS);
    wire logic hit_mask = (paddr_i == ACC_OFF_MASK);
    wire logic unmapped = !(hit_ctrl || hit_status || hit_mask);
    wire logic wr_ctrl = access_phase && pwrite_i && hit_ctrl;
    wire logic wr_status = access_phase && pwrite_i && hit_status;
    wire logic wr_mask = access_phase && pwrite_i && hit_mask;

    // Result and edge detection, edge polarity applied after the compare
    // result inversion
    wire logic result_now = ctrl_q.enable && (sync2_q ^ ctrl_q.invert);
    wire logic result_prev = sample_q ^ ctrl_q.invert;
    wire logic cur_pol = sync2_q ^ ctrl_q.invert;
    wire logic rise = cur_pol && !result_prev;
    wire logic fall = !cur_pol && result_prev;
    wire logic edge_hit = (ctrl_q.edge_sel[0] && rise) || (ctrl_q.edge_sel[1] && fall);
    wire logic event_d = ctrl_q.enable && edge_hit;

    // Read mux
    // reserved bits zero
    wire logic [31:0] ctrl_rd = acc_pack(ctrl_q, result_now) & ACC_CTRL_RD_MASK;
    wire logic [31:0] rd_mux = hit_ctrl ? ctrl_rd :
                               hit_status ? (status_q & ACC_EVT_MASK) :
                               hit_mask ? (mask_q & ACC_EVT_MASK) : 32'h0000_0000;

    // Sticky status: a new event wins over a clear in the same cycle
    wire logic [31:0] status_set = {31'h0, event_q};
    wire logic [31:0] status_clr = wr_status ? pwdata_i : 32'h0000_0000;
    wire logic [31:0] status_d = ((status_q & ~status_clr) | status_set) & ACC_EVT_MASK;

    // Control register
    // fields written as given
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ctrl_q <= acc_unpack(ACC_CTRL_RESET);
        end else if (wr_ctrl) begin
            ctrl_q <= acc_unpack(pwdata_i & ACC_CTRL_WR_MASK);
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            status_q <= 32'h0000_0000;
            mask_q <= ACC_MASK_RESET;
        end else begin
            status_q <= status_d;
            if (wr_mask) begin
                mask_q <= pwdata_i & ACC_EVT_MASK;
            end
        end
    end

    // Read data captured in the setup cycle, held through the access
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            prdata_q <= 32'h0000_0000;
        end else if (setup_phase && !pwrite_i) begin
            prdata_q <= rd_mux;
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            sample_q <= 1'b0;
        end else begin
            sync1_q <= compare_raw_i;
            sync2_q <= sync1_q;
            sample_q <= sync2_q;
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            event_q <= 1'b0;
            pin_q <= 1'b0;
        end else begin
            event_q <= event_d;
            pin_q <= result_now;
        end
    end

    assign prdata_o = prdata_q;
    assign pready_o = 1'b1;
    assign pslverr_o = access_phase && unmapped;
    assign analog_power_o = ctrl_q.enable;
    assign positive_input_select_o = ctrl_q.pos_sel;
    assign negative_input_select_o = ctrl_q.neg_sel;
    assign compare_out_pin_oe_o = ctrl_q.enable && ctrl_q.drive;
    assign compare_out_pin_o = pin_q;
    assign compare_event_o = event_q;
    assign irq_o = |(status_q & mask_q);

    // Checks
    a_reserved_read: assert property (
        @(posedge core_clk_i) disable iff (!arst_n_i)
        (setup_phase && !pwrite_i && hit_ctrl) |=> ((prdata_o & ~ACC_CTRL_RD_MASK) == 32'h0))
        else $error("reserved control bits read nonzero");

    a_enable_only_write: assert property (
        @(posedge core_clk_i) disable iff (!arst_n_i)
        (wr_ctrl && (pwdata_i[ACC_BIT_INVERT] == ctrl_q.invert))
        |=> (ctrl_q.invert == $past(pwdata_i[ACC_BIT_INVERT])))
        else $error("control field changed unexpectedly");

    a_power_follows: assert property (
        @(posedge core_clk_i) disable iff (!arst_n_i)
        !ctrl_q.enable |-> (!analog_power_o && !compare_out_pin_oe_o && !result_now))
        else $error("comparator active while disabled");

    a_pin_value: assert property (
        @(posedge core_clk_i) disable iff (!arst_n_i)
        ($past(ctrl_q.enable) && compare_out_pin_oe_o)
        |-> (compare_out_pin_o == ($past(sync2_q) ^ $past(ctrl_q.invert))))
        else $error("output pin does not carry result");

    a_result_polarity: assert property (
        @(posedge core_clk_i) disable iff (!arst_n_i)
        (ctrl_q.enable && $stable(ctrl_q.invert))
        |-> (result_now == ($past(sync1_q) ^ ctrl_q.invert)))
        else $error("result bit mismatch");

    a_rise_event: assert property (
        @(posedge core_clk_i) disable iff (!arst_n_i)
        (ctrl_q.enable && ctrl_q.edge_sel == ACC_EDGE_RISE && !ctrl_q.invert
            && sync2_q && !sample_q) |=> compare_event_o)
        else $error("rising edge event missed");

    a_fall_only: assert property (
        @(posedge core_clk_i) disable iff (!arst_n_i)
        (ctrl_q.edge_sel == ACC_EDGE_FALL && ctrl_q.invert && sync2_q && !sample_q
            && ctrl_q.enable) |=> compare_event_o)
        else $error("inverted edge event missed");

    a_no_events: assert property (
        @(posedge core_clk_i) disable iff (!arst_n_i)
        (ctrl_q.edge_sel == ACC_EDGE_NONE || !ctrl_q.enable) |=> !compare_event_o)
        else $error("event raised while events off");

    a_single_pulse: assert property (
        @(posedge core_clk_i) disable iff (!arst_n_i)
        compare_event_o |-> ($past(sync2_q) != $past(sample_q)))
        else $error("event pulse without an edge");

    a_sync_delay: assert property (
        @(posedge core_clk_i) disable iff (!arst_n_i)
        $rose(sync1_q) |=> sync2_q ##1 sample_q)
        else $error("synchroniser latency wrong");

    a_sticky_irq: assert property (
        @(posedge core_clk_i) disable iff (!arst_n_i)
        (compare_event_o && mask_q[ACC_EVT_COMPARE] && !wr_mask) |=> irq_o)
        else $error("event did not raise interrupt");

    a_status_set_wins: assert property (
        @(posedge core_clk_i) disable iff (!arst_n_i)
        event_q |=> status_q[ACC_EVT_COMPARE])
        else $error("status bit not set by event");

    a_status_clear: assert property (
        @(posedge core_clk_i) disable iff (!arst_n_i)
        (wr_status && pwdata_i[ACC_EVT_COMPARE] && !event_q) |=> !status_q[ACC_EVT_COMPARE])
        else $error("status bit not cleared by write");

    a_status_sticky: assert property (
        @(posedge core_clk_i) disable iff (!arst_n_i)
        (status_q[ACC_EVT_COMPARE] && !(wr_status && pwdata_i[ACC_EVT_COMPARE]))
        |=> status_q[ACC_EVT_COMPARE])
        else $error("status bit lost without a clear");

    a_mask_write: assert property (
        @(posedge core_clk_i) disable iff (!arst_n_i)
        wr_mask |=> (mask_q[ACC_EVT_COMPARE] == $past(pwdata_i[ACC_EVT_COMPARE])))
        else $error("mask bit not written");

    a_irq_quiet: assert property (
        @(posedge core_clk_i) disable iff (!arst_n_i)
        !(status_q[ACC_EVT_COMPARE] && mask_q[ACC_EVT_COMPARE]) |-> !irq_o)
        else $error("interrupt without a masked-in status bit");

    a_pready_high: assert property (
        @(posedge core_clk_i) disable iff (!arst_n_i)
        access_phase |-> pready_o)
        else $error("access phase without ready");

    a_slverr_mapped: assert property (
        @(posedge core_clk_i) disable iff (!arst_n_i)
        !(access_phase && unmapped) |-> !pslverr_o)
        else $error("error response on a mapped access");

    a_unmapped_read: assert property (
        @(posedge core_clk_i) disable iff (!arst_n_i)
        (setup_phase && !pwrite_i && unmapped) |=> (prdata_o == 32'h0000_0000))
        else $error("unmapped read returned data");

    a_result_readback: assert property (
        @(posedge core_clk_i) disable iff (!arst_n_i)
        (setup_phase && !pwrite_i && hit_ctrl)
        |=> (prdata_o[ACC_BIT_RESULT] == $past(result_now)))
        else $error("result bit not captured");

    a_fields_hold: assert property (
        @(posedge core_clk_i) disable iff (!arst_n_i)
        !wr_ctrl |=> $stable(ctrl_q))
        else $error("control changed without a write");

    a_enable_toggle: assert property (
        @(posedge core_clk_i) disable iff (!arst_n_i)
        (wr_ctrl && ((pwdata_i & 32'h0000_60d3) == (acc_pack(ctrl_q, 1'b0) & 32'h0000_60d3)))
        |=> ($stable(ctrl_q.drive) && $stable(ctrl_q.invert) && $stable(ctrl_q.edge_sel)
            && $stable(ctrl_q.pos_sel) && $stable(ctrl_q.neg_sel)))
        else $error("enable write disturbed other fields");

    a_pos_select: assert property (
        @(posedge core_clk_i) disable iff (!arst_n_i)
        wr_ctrl |=> (positive_input_select_o == $past(pwdata_i[ACC_BIT_POS_SEL])))
        else $error("positive input select not applied");

    a_band_gap_select: assert property (
        @(posedge core_clk_i) disable iff (!arst_n_i)
        (wr_ctrl && pwdata_i[ACC_LSB_NEG_SEL +: 2] == 2'b11)
        |=> (negative_input_select_o == 2'b11))
        else $error("band-gap reference not selected");

    a_neg_select: assert property (
        @(posedge core_clk_i) disable iff (!arst_n_i)
        wr_ctrl |=> (negative_input_select_o == $past(pwdata_i[ACC_LSB_NEG_SEL +: 2])))
        else $error("negative input select not applied");

    a_both_edges: assert property (
        @(posedge core_clk_i) disable iff (!arst_n_i)
        (ctrl_q.enable && ctrl_q.edge_sel == ACC_EDGE_BOTH && sync2_q != sample_q)
        |=> compare_event_o)
        else $error("edge event missed with both edges selected");

    a_fall_event: assert property (
        @(posedge core_clk_i) disable iff (!arst_n_i)
        (ctrl_q.enable && ctrl_q.edge_sel == ACC_EDGE_FALL && !ctrl_q.invert
            && !sync2_q && sample_q) |=> compare_event_o)
        else $error("falling edge event missed");

    a_pin_released: assert property (
        @(posedge core_clk_i) disable iff (!arst_n_i)
        !ctrl_q.drive |-> !compare_out_pin_oe_o)
        else $error("pin driven while drive bit clear");

endmodule

// file: include/acc_pkg.sv
// Package for the analog comparator control block: offsets, field layout,
// reset values, encodings and the control word carrier type.
// Assumes a 32-bit APB with one aligned word per register.
package acc_pkg;

    localparam logic [11:0] ACC_OFF_CTRL = 12'h000;
    localparam logic [11:0] ACC_OFF_STATUS = 12'h004;
    localparam logic [11:0] ACC_OFF_MASK = 12'h008;

    localparam int ACC_BIT_ENABLE = 15;
    localparam int ACC_BIT_DRIVE = 14;
    localparam int ACC_BIT_INVERT = 13;
    localparam int ACC_BIT_RESULT = 8;
    localparam int ACC_LSB_EDGE = 6;
    localparam int ACC_BIT_POS_SEL = 4;
    localparam int ACC_LSB_NEG_SEL = 0;

    localparam logic [31:0] ACC_CTRL_WR_MASK = 32'h0000_e0d3;
    localparam logic [31:0] ACC_CTRL_RD_MASK = 32'h0000_e1d3;
    localparam logic [31:0] ACC_CTRL_RESET = 32'h0000_00c3;

    localparam int ACC_EVT_COMPARE = 0;
    localparam logic [31:0] ACC_EVT_MASK = 32'h0000_0001;
    localparam logic [31:0] ACC_MASK_RESET = 32'h0000_0000;

    typedef enum logic [1:0] {
        ACC_EDGE_NONE = 2'b00,
        ACC_EDGE_RISE = 2'b01,
        ACC_EDGE_FALL = 2'b10,
        ACC_EDGE_BOTH = 2'b11
    } acc_edge_t;

    typedef enum logic [1:0] {
        ACC_NEG_OWN_NEG = 2'b00,
        ACC_NEG_OWN_POS = 2'b01,
        ACC_NEG_OTHER_POS = 2'b10,
        ACC_NEG_BAND_GAP = 2'b11
    } acc_neg_t;

    typedef struct packed {
        logic enable;
        logic drive;
        logic invert;
        acc_edge_t edge_sel;
        logic pos_sel;
        acc_neg_t neg_sel;
    } acc_ctrl_t;

    function automatic acc_ctrl_t acc_unpack(input logic [31:0] w);
        acc_ctrl_t c;
        c.enable = w[ACC_BIT_ENABLE];
        c.drive = w[ACC_BIT_DRIVE];
        c.invert = w[ACC_BIT_INVERT];
        c.edge_sel = acc_edge_t'(w[ACC_LSB_EDGE +: 2]);
        c.pos_sel = w[ACC_BIT_POS_SEL];
        c.neg_sel = acc_neg_t'(w[ACC_LSB_NEG_SEL +: 2]);
        return c;
    endfunction

    function automatic logic [31:0] acc_pack(input acc_ctrl_t c, input logic result);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[ACC_BIT_ENABLE] = c.enable;
        w[ACC_BIT_DRIVE] = c.drive;
        w[ACC_BIT_INVERT] = c.invert;
        w[ACC_BIT_RESULT] = result;
        w[ACC_LSB_EDGE +: 2] = c.edge_sel;
        w[ACC_BIT_POS_SEL] = c.pos_sel;
        w[ACC_LSB_NEG_SEL +: 2] = c.neg_sel;
        return w;
    endfunction

endpackage

// file: verification/acc_analog_model.sv
// Analog side model: pin and reference levels feeding one comparator.
// Assumes the bench sets each level as an 8-bit code.
`timescale 1ns/1ns
module acc_analog_model (
    input wire logic power_i,
    input wire logic pos_sel_i,
    input wire logic [1:0] neg_sel_i,
    input wire logic [7:0] own_pos_i,
    input wire logic [7:0] own_neg_i,
    input wire logic [7:0] other_pos_i,
    input wire logic [7:0] vref_i,
    input wire logic [7:0] gap_i,
    output logic raw_o
);
    logic [7:0] plus;
    logic [7:0] minus;
    assign plus = pos_sel_i ? vref_i : own_pos_i;
    assign minus = neg_sel_i[1] ? (neg_sel_i[0] ? gap_i : other_pos_i)
                                : (neg_sel_i[0] ? own_pos_i : own_neg_i);
    assign raw_o = power_i & (plus > minus);
endmodule

// file: verification/analog_comparator_control_bench.sv
// Self-checking bench for the comparator control block.
// Assumes zero wait state APB and the analog model on the raw input.
`timescale 1ns/1ns
module analog_comparator_control_bench;
import acc_pkg::*;
logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, raw, err;
logic pready, pslverr, pw_o, ps_o, pin, pin_oe, evt, irq;
logic [1:0] ns_o;
logic [11:0] paddr = 12'h000;
logic [31:0] pwdata = 32'h0, prdata, rd, w;
logic [7:0] own_pos = 8'h28, own_neg = 8'h0a, oth = 8'h3c, vref = 8'h32, gap = 8'h1e;
int fails = 0, samples_checked = 0, ev_cnt = 0;
integer seed = 32'he65751fb;
always #2 clk = ~clk;
always @(posedge clk) if (evt === 1'b1) ev_cnt++;
acc_comparator_ctrl dut_u (.core_clk_i(clk), .arst_n_i(rst_n), .psel_i(psel),
    .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .compare_raw_i(raw),
    .analog_power_o(pw_o), .positive_input_select_o(ps_o),
    .negative_input_select_o(ns_o), .compare_out_pin_o(pin),
    .compare_out_pin_oe_o(pin_oe), .compare_event_o(evt), .irq_o(irq));
acc_analog_model model_u (.power_i(pw_o), .pos_sel_i(ps_o), .neg_sel_i(ns_o),
    .own_pos_i(own_pos), .own_neg_i(own_neg), .other_pos_i(oth), .vref_i(vref),
    .gap_i(gap), .raw_o(raw));
task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
        fails++;
        $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
endtask
task automatic give_verdict;
    if (fails == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
endtask
task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
        @(posedge clk);
        n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    err = pslverr;
    if (n >= 16) fails++;
    if (n >= 16) give_verdict();
    psel <= 1'b0;
    pen <= 1'b0;
endtask
task automatic wr_rd(input logic [31:0] v);
    apb(1, 12'h000, v);
    repeat (5) @(posedge clk);
    apb(0, 12'h000, 0);
endtask
task automatic lvl(input logic [7:0] v);
    @(posedge clk);
    own_pos <= v;
    repeat (8) @(posedge clk);
endtask
function automatic logic exp_raw(input logic p, input logic [1:0] ng);
    int pl, mi;
    pl = p ? vref : own_pos;
    mi = ng == 0 ? own_neg : ng == 1 ? own_pos : ng == 2 ? oth : gap;
    return pl > mi;
endfunction
function automatic logic [31:0] exp_ctrl(input logic [31:0] v);
    logic [31:0] e;
    e = v & 32'h0000_e0d3;
    e[8] = v[15] & (exp_raw(v[4], v[1:0]) ^ v[13]);
    return e;
endfunction
initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    apb(0, 12'h000, 0);
    check(rd, 32'h0000_00c3);
    check({pw_o, pin_oe, pin, evt, irq, pready}, 6'h01);
    apb(0, 12'h004, 0);
    check(rd, 0);
    apb(0, 12'h008, 0);
    check(rd, 0);
    apb(0, 12'h00c, 0);
    check(rd, 0);
    check(err, 1);
    repeat (4) begin
        w = $random(seed);
        wr_rd(w);
        check(rd, exp_ctrl(w));
        wr_rd(w ^ 32'h8000);
        check(rd, exp_ctrl(w ^ 32'h8000));
    end
    for (int i = 0; i < 8; i++) begin
        w = 32'h8000 | (i[2] << 4) | i[1:0];
        wr_rd(w);
        check(rd, exp_ctrl(w));
        check({pw_o, ps_o, ns_o}, {1'b1, w[4], w[1:0]});
    end
    apb(1, 12'h008, 1);
    for (int i = 0; i < 8; i++) begin
        w = 32'h8000 | (i[2] << 13) | (i[2] << 14) | (i[1:0] << 6);
        lvl(8'h05);
        apb(1, 12'h000, w);
        repeat (6) @(posedge clk);
        apb(1, 12'h004, 1);
        ev_cnt = 0;
        lvl(8'h28);
        check(ev_cnt, i[2] ? i[1] : i[0]);
        check({pin_oe, pin}, {i[2], ~i[2]});
        lvl(8'h05);
        check(ev_cnt, i[0] + i[1]);
        check(irq, i[1:0] != 0);
        apb(1, 12'h004, 1);
        repeat (2) @(posedge clk);
        check(irq, 0);
    end
    lvl(8'h28);
    ev_cnt = 0;
    apb(1, 12'h000, 32'h0000_60c0);
    lvl(8'h05);
    lvl(8'h28);
    check(ev_cnt, 0);
    check({pw_o, pin_oe, pin}, 0);
    check(irq, 1);
    give_verdict();
end
endmodule
